// file: cei_defines.svh
// Offsets, bit positions, reset values and sizes of the interrupt masking.
`ifndef CEI_DEFINES_SVH
`define CEI_DEFINES_SVH

`define CEI_NUM_SRC         9
`define CEI_ADDR_W          8

`define CEI_OFF_ENABLE      8'h00
`define CEI_OFF_GATED       8'h04
`define CEI_OFF_RAW         8'h08
`define CEI_OFF_CLEAR       8'h0C

`define CEI_BIT_DECODE_ERR  8
`define CEI_BIT_SLAVE_ERR   7
`define CEI_BIT_DATA_RD     6
`define CEI_BIT_TAG_RD      5
`define CEI_BIT_DATA_WR     4
`define CEI_BIT_TAG_WR      3
`define CEI_BIT_DATA_PAR    2
`define CEI_BIT_TAG_PAR     1
`define CEI_BIT_EVT_CNT     0

`define CEI_AUX_NS_BIT      27

`define CEI_ENABLE_RESET    9'h000
`define CEI_RAW_RESET       9'h000
`define CEI_WORD_RESET      32'h0000_0000

`endif

// file: cei_pkg.sv
// Types shared by the cache error interrupt masking block.
package cei_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
		logic        nonsecure;
	} cei_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        decerr;
	} cei_rsp_t;

	typedef struct packed {
		logic next_level_decode_error;
		logic next_level_slave_error;
		logic data_ram_read_error;
		logic tag_ram_read_error;
		logic data_ram_write_error;
		logic tag_ram_write_error;
		logic data_ram_parity_error;
		logic tag_ram_parity_error;
		logic event_counter_overflow;
	} cei_src_bits_t;

	typedef enum logic [2:0] {
		CEI_SEL_NONE,
		CEI_SEL_ENABLE,
		CEI_SEL_GATED,
		CEI_SEL_RAW,
		CEI_SEL_CLEAR
	} cei_sel_t;

endpackage : cei_pkg

// file: cei_raw_status.sv
// Sticky raw interrupt status with write-one-to-clear.
module cei_raw_status #(
	parameter int unsigned N = 9
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [N-1:0] set_in,
	input  wire logic [N-1:0] clear_in,
	output logic      [N-1:0] raw_out
);
	import cei_pkg::*;

	// A set in the same cycle as its clear wins, so no event is lost.
	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_bit
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					raw_out[k] <= 1'b0;
				end else if (set_in[k]) begin
					raw_out[k] <= 1'b1;
				end else if (clear_in[k]) begin
					raw_out[k] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : cei_raw_status

// file: cei_mask_gate.sv
// Per-source gating of raw status onto registered interrupt pins.
module cei_mask_gate #(
	parameter int unsigned N = 9
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [N-1:0] raw_in,
	input  wire logic [N-1:0] enable_in,
	output logic      [N-1:0] gated_out,
	output logic      [N-1:0] pin_out,
	output logic              combined_out
);
	import cei_pkg::*;

	assign gated_out = raw_in & enable_in;

	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_pin
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					pin_out[k] <= 1'b0;
				end else begin
					pin_out[k] <= gated_out[k];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			combined_out <= 1'b0;
		end else begin
			combined_out <= |gated_out;
		end
	end

endmodule : cei_mask_gate

// file: cei_top.sv
// Register slave, enable masking and interrupt pins for cache errors.
//
// Our own choices: the register offsets and the strobed register port.
`include "cei_defines.svh"
module cei_top (
	input  wire logic                  clk_in,
	input  wire logic                  nrst_in,
	input  wire cei_pkg::cei_req_t     req_in,
	input  wire logic [31:0]           aux_ctrl_in,
	input  wire cei_pkg::cei_src_bits_t src_in,
	output cei_pkg::cei_rsp_t          rsp_out,
	output logic [`CEI_NUM_SRC-1:0]    src_irq_out,
	output logic                       combined_interrupt_out
);
	import cei_pkg::*;

	localparam int unsigned N = `CEI_NUM_SRC;

	// ==============================================================
	// Address decode
	// ==============================================================

	function automatic cei_sel_t cei_decode(
		input logic [`CEI_ADDR_W-1:0] addr
	);
		cei_sel_t sel;
		sel = CEI_SEL_NONE;
		unique case (addr)
			`CEI_OFF_ENABLE: sel = CEI_SEL_ENABLE;
			`CEI_OFF_GATED:  sel = CEI_SEL_GATED;
			`CEI_OFF_RAW:    sel = CEI_SEL_RAW;
			`CEI_OFF_CLEAR:  sel = CEI_SEL_CLEAR;
			default:         sel = CEI_SEL_NONE;
		endcase
		return sel;
	endfunction : cei_decode

	// Widens a source vector to a bus word with upper bits zero.
	function automatic logic [31:0] cei_word(
		input logic [N-1:0] bits
	);
		logic [31:0] w;
		w = `CEI_WORD_RESET;
		w[N-1:0] = bits;
		return w;
	endfunction : cei_word

	cei_sel_t       wr_sel;
	cei_sel_t       rd_sel;
	logic           protected_wr;
	logic           ns_refused;
	logic           enable_wr_ok;
	logic           clear_wr_ok;
	logic [N-1:0]   src_vec;
	logic [N-1:0]   clear_vec;
	logic [N-1:0]   raw_q;
	logic [N-1:0]   gated;
	logic [N-1:0]   enable_reg;
	logic [N-1:0]   enable_next;
	logic [31:0]    rdata_next;
	cei_rsp_t       rsp_reg;
	cei_rsp_t       rsp_next;

	assign wr_sel = req_in.wr ? cei_decode(req_in.addr) : CEI_SEL_NONE;
	assign rd_sel = req_in.rd ? cei_decode(req_in.addr) : CEI_SEL_NONE;

	// ==============================================================
	// Security check on protected writes
	// ==============================================================

	assign protected_wr = (wr_sel == CEI_SEL_ENABLE) ||
	                      (wr_sel == CEI_SEL_CLEAR);

	// Non-secure writes to the enable or clear register need the aux control permission bit.
	assign ns_refused = protected_wr && req_in.nonsecure &&
	                    !aux_ctrl_in[`CEI_AUX_NS_BIT];

	assign enable_wr_ok = (wr_sel == CEI_SEL_ENABLE) && !ns_refused;
	assign clear_wr_ok  = (wr_sel == CEI_SEL_CLEAR) && !ns_refused;

	// ==============================================================
	// Source mapping
	// ==============================================================

	always_comb begin
		src_vec = '0;
		src_vec[`CEI_BIT_DECODE_ERR] =
			src_in.next_level_decode_error;
		src_vec[`CEI_BIT_SLAVE_ERR] =
			src_in.next_level_slave_error;
		src_vec[`CEI_BIT_DATA_RD] =
			src_in.data_ram_read_error;
		src_vec[`CEI_BIT_TAG_RD] =
			src_in.tag_ram_read_error;
		src_vec[`CEI_BIT_DATA_WR] =
			src_in.data_ram_write_error;
		src_vec[`CEI_BIT_TAG_WR] =
			src_in.tag_ram_write_error;
		src_vec[`CEI_BIT_DATA_PAR] =
			src_in.data_ram_parity_error;
		src_vec[`CEI_BIT_TAG_PAR] =
			src_in.tag_ram_parity_error;
		src_vec[`CEI_BIT_EVT_CNT] =
			src_in.event_counter_overflow;
	end

	// ==============================================================
	// Raw status and clear
	// ==============================================================

	// Only a permitted clear write reaches the raw bits.
	assign clear_vec = clear_wr_ok ? req_in.wdata[N-1:0] : '0;

	// The raw bits ignore the enables entirely.
	cei_raw_status #(
		.N (N)
	) u_raw (
		.clk_in   (clk_in),
		.nrst_in  (nrst_in),
		.set_in   (src_vec),
		.clear_in (clear_vec),
		.raw_out  (raw_q)
	);

	// ==============================================================
	// Enable register
	// ==============================================================

	always_comb begin
		enable_next = enable_reg;
		if (enable_wr_ok) begin
			enable_next = req_in.wdata[N-1:0];
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			enable_reg <= `CEI_ENABLE_RESET;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// ==============================================================
	// Gating onto pins
	// ==============================================================

	// Each pin and the combined line are masked by the same bit.
	cei_mask_gate #(
		.N (N)
	) u_gate (
		.clk_in       (clk_in),
		.nrst_in      (nrst_in),
		.raw_in       (raw_q),
		.enable_in    (enable_reg),
		.gated_out    (gated),
		.pin_out      (src_irq_out),
		.combined_out (combined_interrupt_out)
	);

	// ==============================================================
	// Read data and response
	// ==============================================================

	// The gated status is readable regardless of the security flag.
	always_comb begin
		rdata_next = `CEI_WORD_RESET;
		unique case (rd_sel)
			CEI_SEL_ENABLE: rdata_next = cei_word(enable_reg);
			CEI_SEL_GATED:  rdata_next = cei_word(gated);
			CEI_SEL_RAW:    rdata_next = cei_word(raw_q);
			CEI_SEL_CLEAR:  rdata_next = `CEI_WORD_RESET;
			CEI_SEL_NONE:   rdata_next = `CEI_WORD_RESET;
		endcase
	end

	always_comb begin
		rsp_next.rdata  = rdata_next;
		rsp_next.decerr = ns_refused;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	assign rsp_out = rsp_reg;

	// ==============================================================
	// Checks
	// ==============================================================

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_enable_write;
		enable_wr_ok;
	endsequence

	sequence s_refused_write;
		req_in.wr && (cei_decode(req_in.addr) == CEI_SEL_ENABLE) &&
		req_in.nonsecure && !aux_ctrl_in[`CEI_AUX_NS_BIT];
	endsequence

	sequence s_gated_read;
		req_in.rd && (cei_decode(req_in.addr) == CEI_SEL_GATED);
	endsequence

	sequence s_enabled_event;
		(|(src_vec & enable_reg)) && !enable_wr_ok;
	endsequence

	sequence s_refused_clear;
		req_in.wr && (cei_decode(req_in.addr) == CEI_SEL_CLEAR) &&
		req_in.nonsecure && !aux_ctrl_in[`CEI_AUX_NS_BIT];
	endsequence

	sequence s_status_write;
		req_in.wr && (cei_decode(req_in.addr) == CEI_SEL_GATED);
	endsequence

	sequence s_zero_read;
		req_in.rd && ((cei_decode(req_in.addr) == CEI_SEL_NONE) ||
		              (cei_decode(req_in.addr) == CEI_SEL_CLEAR));
	endsequence

	sequence s_raw_read;
		req_in.rd && (cei_decode(req_in.addr) == CEI_SEL_RAW);
	endsequence

	sequence s_enable_read;
		req_in.rd && (cei_decode(req_in.addr) == CEI_SEL_ENABLE);
	endsequence

	chk_pin_masked: assert property (
		(src_irq_out & ~$past(enable_reg)) == '0
	) else $error("Interrupt pin high while its enable was clear.");

	chk_combined_or: assert property (
		combined_interrupt_out == (|$past(gated))
	) else $error("Combined line differs from OR of gated bits.");

	chk_event_reaches: assert property (
		s_enabled_event |=> ##1 combined_interrupt_out
	) else $error("Enabled event did not reach combined line.");

	chk_enable_load: assert property (
		s_enable_write |=> enable_reg == $past(req_in.wdata[N-1:0])
	) else $error("Enable register did not take written value.");

	chk_enable_hold: assert property (
		!enable_wr_ok |=> $stable(enable_reg)
	) else $error("Enable register changed without a permitted write.");

	chk_ns_refused: assert property (
		s_refused_write |=> rsp_out.decerr && $stable(enable_reg)
	) else $error("Refused write not answered with decode error.");

	chk_no_false_err: assert property (
		!ns_refused |=> !rsp_out.decerr
	) else $error("Decode error without a refused write.");

	chk_gated_read: assert property (
		s_gated_read |=>
			rsp_out.rdata == cei_word($past(raw_q & enable_reg))
	) else $error("Gated status read differs from raw AND enable.");

	chk_upper_zero: assert property (
		rsp_out.rdata[31:N] == '0
	) else $error("Reserved read bits are not zero.");

	chk_raw_clear: assert property (
		clear_wr_ok |=> raw_q == (($past(raw_q) &
			~$past(req_in.wdata[N-1:0])) | $past(src_vec))
	) else $error("Clear write did not act on the raw bits.");

	chk_raw_sticky: assert property (
		!clear_wr_ok |=> (raw_q & $past(raw_q)) == $past(raw_q)
	) else $error("Raw bit fell without a clear write.");

	chk_reset_values: assert property (
		@(posedge clk_in) disable iff (1'b0)
		!nrst_in |-> (enable_reg == '0) && (gated == '0)
	) else $error("Enables or gated status not zero in reset.");

	chk_pins_follow: assert property (
		src_irq_out == $past(gated)
	) else $error("Pins differ from gated status of the last cycle.");

	chk_combined_pin: assert property (
		combined_interrupt_out == (|src_irq_out)
	) else $error("Combined line differs from OR of the pins.");

	chk_raw_set: assert property (
		(|src_vec) |=> (raw_q & $past(src_vec)) == $past(src_vec)
	) else $error("Source event did not set its raw bit.");

	chk_refused_clear: assert property (
		s_refused_clear |=> rsp_out.decerr &&
			((raw_q & $past(raw_q)) == $past(raw_q))
	) else $error("Refused clear write acted on the raw bits.");

	chk_status_write: assert property (
		s_status_write |=> $stable(enable_reg) &&
			((raw_q & $past(raw_q)) == $past(raw_q))
	) else $error("Write to the gated status had an effect.");

	chk_zero_read: assert property (
		s_zero_read |=> rsp_out.rdata == '0
	) else $error("Clear or unmapped read returned nonzero data.");

	chk_raw_read: assert property (
		s_raw_read |=> rsp_out.rdata == cei_word($past(raw_q))
	) else $error("Raw status read differs from the raw bits.");

	chk_enable_read: assert property (
		s_enable_read |=> rsp_out.rdata == cei_word($past(enable_reg))
	) else $error("Enable read differs from the enable bits.");

	chk_reset_outputs: assert property (
		@(posedge clk_in) disable iff (1'b0)
		!nrst_in |-> (src_irq_out == '0) && !combined_interrupt_out &&
			(rsp_out == '0)
	) else $error("Outputs not zero in reset.");

endmodule : cei_top

// file: cei_irq_sink.sv
// Behavioural system interrupt receiver watching the interrupt lines.
module cei_irq_sink (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic [8:0] line_in,
	input  wire logic       combined_in,
	output logic            mismatch_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ====================================================================
	// Line agreement
	// The receiver trusts the combined line alone, so it must never
	// disagree with the individual lines in any cycle.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mismatch_out <= 1'b0;
		end else if (combined_in !== (|line_in)) begin
			mismatch_out <= 1'b1;
		end
	end

endmodule : cei_irq_sink

// file: testbench.sv
// Self-checking bench for the cache error interrupt masking block.
`include "cei_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import cei_pkg::*;

	localparam logic [7:0] A_EN  = `CEI_OFF_ENABLE;
	localparam logic [7:0] A_GT  = `CEI_OFF_GATED;
	localparam logic [7:0] A_RAW = `CEI_OFF_RAW;
	localparam logic [7:0] A_CLR = `CEI_OFF_CLEAR;

	logic          clk;
	logic          nrst;
	cei_req_t      req;
	logic [31:0]   aux;
	cei_src_bits_t src;
	cei_rsp_t      rsp;
	logic [8:0]    pins;
	logic          comb;
	logic          sink_err;
	int            n_fail;
	int            samples_checked;
	int            en_m;
	int            raw_m;
	int            order[$] = '{8, 7, 6, 5, 4, 3, 2, 1, 0};

	cei_top DUT (
		.clk_in                 (clk),
		.nrst_in                (nrst),
		.req_in                 (req),
		.aux_ctrl_in            (aux),
		.src_in                 (src),
		.rsp_out                (rsp),
		.src_irq_out            (pins),
		.combined_interrupt_out (comb)
	);

	cei_irq_sink SINK (
		.clk_in       (clk),
		.nrst_in      (nrst),
		.line_in      (pins),
		.combined_in  (comb),
		.mismatch_out (sink_err)
	);

	always #25 clk = ~clk;

	// ====================================================================
	// Reporting
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// ====================================================================
	// Register bus and sources
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
		input logic ns);
		logic refuse;
		@(posedge clk);
		refuse = ns && !aux[`CEI_AUX_NS_BIT] && (a == A_EN || a == A_CLR);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, nonsecure: ns};
		@(posedge clk);
		req.wr <= 1'b0;
		#1 check("decode error", 32'(rsp.decerr), 32'(refuse));
		if (!refuse && a == A_EN)
			en_m = d & 32'h1FF;
		if (!refuse && a == A_CLR)
			raw_m = raw_m & ~d;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, input logic ns,
		input logic [31:0] exp, input string what);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, nonsecure: ns};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 check(what, rsp.rdata, exp);
	endtask : bus_rd

	task automatic pulse(input logic [8:0] v);
		@(posedge clk);
		src <= cei_src_bits_t'(v);
		@(posedge clk);
		src <= cei_src_bits_t'(9'h000);
		raw_m = raw_m | 32'(v);
	endtask : pulse

	task automatic check_pins();
		repeat (3) @(posedge clk);
		#1 check("pins", 32'(pins), 32'(raw_m & en_m));
		check("combined", 32'(comb), 32'((raw_m & en_m) != 0));
	endtask : check_pins

	// ====================================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		nrst = 1'b1;
		req = '0;
		aux = 32'h0000_0000;
		src = '0;
		n_fail = 0;
		samples_checked = 0;
		en_m = 0;
		raw_m = 0;
		// Reset falls after time zero so every flip-flop sees a clean edge.
		#1 nrst = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		void'($urandom(32'h2c46));
		bus_rd(A_EN, 1'b0, 32'h0, "enable reset");
		bus_rd(A_GT, 1'b0, 32'h0, "gated reset");
		check_pins();
		foreach (order[i]) begin
			bus_wr(A_EN, $urandom(), 1'b0);
			check_pins();
			pulse(9'(1 << order[i]));
			check_pins();
			bus_rd(A_GT, 1'(order[i]), 32'(raw_m & en_m), "gated");
			bus_rd(A_RAW, 1'b0, 32'(raw_m), "raw");
			bus_rd(A_EN, 1'b0, 32'(en_m), "enable");
		end
		bus_wr(A_EN, 32'hFFFF_FFFF, 1'b0);
		check_pins();
		bus_wr(A_EN, 32'h0000_0000, 1'b0);
		check_pins();
		bus_wr(A_EN, 32'h0000_01FF, 1'b1);
		bus_rd(A_EN, 1'b1, 32'(en_m), "enable kept");
		bus_wr(A_CLR, 32'h0000_01FF, 1'b1);
		aux <= 32'h0800_0000;
		bus_wr(A_EN, 32'h0000_00AA, 1'b1);
		bus_wr(A_GT, 32'h0000_01FF, 1'b0);
		bus_wr(A_RAW, 32'h0000_0000, 1'b0);
		bus_rd(A_GT, 1'b1, 32'(raw_m & en_m), "gated ro");
		bus_wr(A_CLR, 32'h0000_00F0, 1'b1);
		bus_rd(A_RAW, 1'b0, 32'(raw_m), "raw clear");
		check_pins();
		bus_rd(8'h40, 1'b0, 32'h0, "unmapped");
		bus_rd(A_CLR, 1'b0, 32'h0, "clear reads");
		check("sink", 32'(sink_err), 32'h0);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		en_m = 0;
		raw_m = 0;
		bus_rd(A_EN, 1'b0, 32'h0, "enable rerun");
		bus_rd(A_GT, 1'b0, 32'h0, "gated rerun");
		bus_rd(A_RAW, 1'b0, 32'h0, "raw rerun");
		check_pins();
		bus_wr(A_CLR, 32'hFFFF_FFFF, 1'b0);
		check_pins();
		check("sink", 32'(sink_err), 32'h0);
		final_report();
	end

	// The tests take well under a thousand cycles; four thousand is ample.
	initial begin
		#(50 * 4000);
		n_fail++;
		final_report();
	end

endmodule : testbench
